// [hbsm_regs.vh]
// Register map, field positions and timing constants of the half-bridge mode controller
`ifndef HBSM_REGS_VH
`define HBSM_REGS_VH

`define HBSM_CTRL_OFF 8'h00
`define HBSM_STAT_OFF 8'h04
`define HBSM_FAULT_OFF 8'h08

`define HBSM_CTRL_SLEEP_N 0
`define HBSM_CTRL_RECOVERY 1
`define HBSM_CTRL_SUPPLY_OK 2
`define HBSM_CTRL_FCLR 3
`define HBSM_CTRL_RESET 32'h0000_0001

`define HBSM_STAT_SLEEP 0
`define HBSM_STAT_READY 1
`define HBSM_STAT_FAULT 2

`define HBSM_FAULT_OCP_LSB 0
`define HBSM_FAULT_OT 4

`define HBSM_CLK_MHZ 200
`define HBSM_CLR_MIN_US 20
`define HBSM_CLR_MAX_US 40
`define HBSM_UNDEF_MAX_US 120
`define HBSM_DEAD_NS 300
`define HBSM_CLR_MIN_CYC (`HBSM_CLR_MIN_US * `HBSM_CLK_MHZ)
`define HBSM_CLR_MAX_CYC (`HBSM_CLR_MAX_US * `HBSM_CLK_MHZ)
`define HBSM_UNDEF_MAX_CYC (`HBSM_UNDEF_MAX_US * `HBSM_CLK_MHZ)
`define HBSM_DEAD_CYC ((`HBSM_DEAD_NS * `HBSM_CLK_MHZ + 999) / 1000)
`define HBSM_SLEEP_ENTRY_CYC 32'd24000
`define HBSM_WAKE_CYC 32'd200000

`endif

// [hbsm_top.v]
// Sleep, wake, fault-clear and dead-time control of a four-channel half-bridge driver
`timescale 1ns/100ps
`include "hbsm_regs.vh"

// Operation
// - Low sleep request disables bridges, regulator, pump
// - Sleep entered only after entry delay
// - Raising sleep request wakes automatically
// - Inputs ignored until wake delay passes
// - Operate only when awake and supply good
// - 20-40 us low pulse clears latched faults
// - 40-120 us low pulse clears faults
// - Clear pulse leaves pump and blocks alone
// - Four bridges, independent input and enable
// - 300 ns dead time on side change
// - Recovery select low keeps faults latched
// - Fault flag pulled low while fault held
module hbsm_top #(
  parameter [31:0] SLEEP_ENTRY_CYC = `HBSM_SLEEP_ENTRY_CYC,
  parameter [31:0] WAKE_CYC = `HBSM_WAKE_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] bridge_drive_input,
  input wire [3:0] bridge_enable_input,
  input wire [3:0] ocp_detect,
  input wire ot_detect,
  output reg [3:0] high_side_on,
  output reg [3:0] low_side_on,
  output reg charge_pump_en,
  output reg regulator_en,
  output reg logic_en,
  output wire fault_flag_low_o,
  output wire fault_flag_low_oe
);

  // Run, pending low, sleep and wake-delay states
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_PEND = 2'd1;
  localparam [1:0] ST_SLEEP = 2'd2;
  localparam [1:0] ST_WAKE = 2'd3;

  // Low-time windows in clock cycles, held against the low counter
  localparam [31:0] CLR_MIN_CYC = `HBSM_CLR_MIN_CYC;
  localparam [31:0] UNDEF_MAX_CYC = `HBSM_UNDEF_MAX_CYC;
  // Gate-off time after a side change, rounded up to whole cycles
  localparam [31:0] DEAD_WIDE = `HBSM_DEAD_CYC;
  localparam [7:0] DEAD_CYC = DEAD_WIDE[7:0];

  reg [31:0] ctrl_q;
  reg [1:0] state_q;
  reg [31:0] low_cnt_q;
  reg [31:0] wake_cnt_q;
  reg [3:0] ocp_q;
  reg ot_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg sleep_req_q;
  // Set while a low on the sleep request interrupted the wake delay
  reg wake_pend_q;

  // Supply and pin levels arrive as control-register bits
  wire sleep_request_low = ctrl_q[`HBSM_CTRL_SLEEP_N];
  wire recovery_auto = ctrl_q[`HBSM_CTRL_RECOVERY];
  wire supply_ok = ctrl_q[`HBSM_CTRL_SUPPLY_OK];
  wire rise = sleep_request_low & ~sleep_req_q;
  wire asleep = (state_q == ST_SLEEP);
  wire ready = (state_q == ST_RUN) & supply_ok;
  // A supply below lockout also pulls the flag
  wire fault_any = (|ocp_q) | ot_q | ~supply_ok;
  // A rising edge after a low of 20..120 us clears latches; faults in 40..120 also clear
  wire clr_pulse = rise && (low_cnt_q > CLR_MIN_CYC) &&
    (low_cnt_q <= UNDEF_MAX_CYC);
  wire sw_clr;

  // AXI4-Lite write: address and data taken independently, response after both
  // A held item keeps its ready low, so a second one waits for the response
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready = ~w_hold_q;
  assign s_axi_arready = ~s_axi_rvalid;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign sw_clr = wr_go && aw_addr_q == `HBSM_CTRL_OFF && w_strb_q[0] &&
    w_data_q[`HBSM_CTRL_FCLR];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      ctrl_q <= `HBSM_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        if (aw_addr_q == `HBSM_CTRL_OFF) begin
          s_axi_bresp <= 2'b00;
          if (w_strb_q[0]) begin
            ctrl_q <= {29'd0, w_data_q[2:0]};
          end
        end else if (aw_addr_q == `HBSM_STAT_OFF || aw_addr_q == `HBSM_FAULT_OFF) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads answer the edge after the address is taken; unknown offsets give SLVERR
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `HBSM_CTRL_OFF: s_axi_rdata <= ctrl_q;
        `HBSM_STAT_OFF: s_axi_rdata <= {29'd0, fault_any, ready, asleep};
        `HBSM_FAULT_OFF: s_axi_rdata <= {27'd0, ot_q, ocp_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Mode sequencing: the low counter times every low on the sleep request
  // and saturates, so a very long low still reads as a full sleep request
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_WAKE;
      low_cnt_q <= 32'd0;
      wake_cnt_q <= 32'd0;
      // Reset value is the awake level, so release never looks like a rising edge
      sleep_req_q <= 1'b1;
      wake_pend_q <= 1'b0;
    end else begin
      sleep_req_q <= sleep_request_low;
      if (!sleep_request_low) begin
        if (low_cnt_q != 32'hFFFF_FFFF) begin
          low_cnt_q <= low_cnt_q + 32'd1;
        end
      end else begin
        low_cnt_q <= 32'd0;
      end
      case (state_q)
        ST_RUN: begin
          if (!sleep_request_low) begin
            state_q <= ST_PEND;
            wake_pend_q <= 1'b0;
          end
        end
        ST_PEND: begin
          // Short pulses return without ever sleeping, so the pump is untouched
          if (sleep_request_low) begin
            // A pulse inside the wake delay resumes it instead of skipping it
            if (wake_pend_q) begin
              state_q <= ST_WAKE;
            end else begin
              state_q <= ST_RUN;
            end
          end else if (low_cnt_q + 32'd1 >= SLEEP_ENTRY_CYC &&
              low_cnt_q >= UNDEF_MAX_CYC) begin
            // Entry never comes before the undefined window ends: shorter lows only clear
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sleep_request_low) begin
            state_q <= ST_WAKE;
            wake_cnt_q <= 32'd0;
          end
        end
        ST_WAKE: begin
          if (!sleep_request_low) begin
            state_q <= ST_PEND;
            wake_pend_q <= 1'b1;
          end else if (wake_cnt_q + 32'd1 >= WAKE_CYC) begin
            state_q <= ST_RUN;
          end else begin
            wake_cnt_q <= wake_cnt_q + 32'd1;
          end
        end
        default: state_q <= ST_SLEEP;
      endcase
    end
  end

  // Fault latches: detection sets win over any clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      ocp_q <= 4'h0;
      ot_q <= 1'b0;
    end else begin
      if (clr_pulse || sw_clr || asleep) begin
        ocp_q <= ocp_detect;
        ot_q <= ot_detect;
      end else if (recovery_auto) begin
        // Auto recovery: each latch follows its detector
        ocp_q <= ocp_detect;
        ot_q <= ot_detect;
      end else begin
        ocp_q <= ocp_q | ocp_detect;
        ot_q <= ot_q | ot_detect;
      end
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high
  assign fault_flag_low_o = 1'b0;
  assign fault_flag_low_oe = fault_any & logic_en;

  always @(posedge aclk) begin
    if (!aresetn) begin
      charge_pump_en <= 1'b0;
      regulator_en <= 1'b0;
      logic_en <= 1'b0;
    end else begin
      // Overtemperature stops the pump; overcurrent leaves it running
      charge_pump_en <= ~asleep & supply_ok & ~ot_q;
      regulator_en <= ~asleep;
      logic_en <= ~asleep;
    end
  end

  // Per-bridge dead-time generator
  // Counting restarts on every side change or re-enable
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_br
      reg [7:0] dt_q;
      reg side_q;
      wire go = ready & bridge_enable_input[i] & ~ocp_q[i] & ~ot_q;
      always @(posedge aclk) begin
        if (!aresetn) begin
          dt_q <= 8'd0;
          side_q <= 1'b0;
          high_side_on[i] <= 1'b0;
          low_side_on[i] <= 1'b0;
        end else if (!go) begin
          dt_q <= 8'd0;
          side_q <= bridge_drive_input[i];
          high_side_on[i] <= 1'b0;
          low_side_on[i] <= 1'b0;
        end else if (bridge_drive_input[i] != side_q) begin
          side_q <= bridge_drive_input[i];
          dt_q <= 8'd0;
          high_side_on[i] <= 1'b0;
          low_side_on[i] <= 1'b0;
        end else if (dt_q < DEAD_CYC) begin
          dt_q <= dt_q + 8'd1;
          high_side_on[i] <= 1'b0;
          low_side_on[i] <= 1'b0;
        end else begin
          high_side_on[i] <= side_q;
          low_side_on[i] <= ~side_q;
        end
      end
    end
  endgenerate

endmodule

// [hbsm_chk_asserts.sv]
// Concurrent checks on the mode controller ports
`timescale 1ns/100ps
module hbsm_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [3:0] ocp_detect,
  input wire [3:0] high_side_on,
  input wire [3:0] low_side_on,
  input wire charge_pump_en,
  input wire regulator_en,
  input wire logic_en,
  input wire ot_detect,
  input wire fault_flag_low_o,
  input wire fault_flag_low_oe
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_off;
    (high_side_on | low_side_on) == 4'h0;
  endsequence
  property p_noshoot;
    (high_side_on & low_side_on) == 4'h0;
  endproperty
  a_noshoot: assert property (p_noshoot) else $error("shoot");
  property p_dead;
    $fell(high_side_on[0]) |-> !low_side_on[0] [*8];
  endproperty
  a_dead: assert property (p_dead) else $error("dead");
  property p_sleep;
    !regulator_en |-> s_off ##0 !charge_pump_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_drop;
    $fell(regulator_en) |-> !charge_pump_en && !logic_en;
  endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_wake;
    $rose(regulator_en) |-> s_off [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_flag;
    ot_detect |=> fault_flag_low_oe;
  endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_od;
    ocp_detect != 4'h0 |=> fault_flag_low_oe && !fault_flag_low_o;
  endproperty
  a_od: assert property (p_od) else $error("od");
  property p_rref;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rref: assert property (p_rref) else $error("rref");
endmodule
bind hbsm_top hbsm_chk u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .ocp_detect, .high_side_on,
  .low_side_on, .charge_pump_en, .regulator_en, .logic_en, .ot_detect, .fault_flag_low_o,
  .fault_flag_low_oe);

// [hbsm_load.sv]
// Load and pull-up model on the bridge side of the controller
`timescale 1ns/100ps
module hbsm_load (
  input wire aclk,
  input wire short_req,
  input wire hot_req,
  input wire [3:0] high_side_on,
  input wire fault_flag_low_o,
  input wire fault_flag_low_oe,
  output reg [3:0] ocp_detect,
  output reg ot_detect,
  output wire fault_n
);
  // Pull-up holds the flag high unless the device sinks it
  assign fault_n = fault_flag_low_oe ? fault_flag_low_o : 1'b1;
  // A short to ground only trips a bridge whose high side conducts
  always @(posedge aclk) begin
    ocp_detect <= {4{short_req}} & high_side_on;
    ot_detect <= hot_req;
  end
endmodule

// [test_half_bridge_sleep_mode_control.sv]
// Self-checking bench for the half-bridge mode controller
`timescale 1ns/100ps
module test_half_bridge_sleep_mode_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] bridge_drive_input = 4'h0;
  logic [3:0] bridge_enable_input = 4'h0;
  logic short_req = 1'b0;
  logic hot_req = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] high_side_on, low_side_on, ocp_detect;
  wire charge_pump_en, regulator_en, logic_en, fault_flag_low_o, fault_flag_low_oe;
  wire ot_detect, fault_n;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  hbsm_top #(.SLEEP_ENTRY_CYC(32'd1), .WAKE_CYC(32'd20)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .bridge_drive_input(bridge_drive_input), .bridge_enable_input(bridge_enable_input),
    .ocp_detect(ocp_detect), .ot_detect(ot_detect), .high_side_on(high_side_on),
    .low_side_on(low_side_on), .charge_pump_en(charge_pump_en), .regulator_en(regulator_en),
    .logic_en(logic_en), .fault_flag_low_o(fault_flag_low_o),
    .fault_flag_low_oe(fault_flag_low_oe));
  hbsm_load u_load (.aclk(aclk), .short_req(short_req), .hot_req(hot_req),
    .high_side_on(high_side_on), .fault_flag_low_o(fault_flag_low_o),
    .fault_flag_low_oe(fault_flag_low_oe), .ocp_detect(ocp_detect), .ot_detect(ot_detect),
    .fault_n(fault_n));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        @(posedge aclk iff s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        @(posedge aclk iff s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    @(posedge aclk iff s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk iff s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_regs();
    rd(8'h00);
    chk(d, 32'h0000_0001);
    chk(r, 2'h0);
    rd(8'h0C);
    chk(d, 32'h0);
    chk(r, 2'h2);
    wr(8'h0C, 32'h0000_0005);
    chk(r, 2'h2);
    wr(8'h04, 32'hFFFF_FFFF);
    chk(r, 2'h0);
  endtask
  task automatic t_bridge();
    wr(8'h00, 32'h0000_0005);
    repeat (30) @(posedge aclk);
    rd(8'h04);
    chk(d[1], 1'b1);
    bridge_drive_input <= 4'h5;
    bridge_enable_input <= 4'hD;
    repeat (80) @(posedge aclk);
    chk({high_side_on, low_side_on}, 8'h58);
    bridge_drive_input <= 4'h4;
    repeat (30) @(posedge aclk);
    chk({high_side_on, low_side_on}, 8'h48);
    repeat (40) @(posedge aclk);
    chk({high_side_on, low_side_on}, 8'h49);
  endtask
  task automatic t_fault();
    int lows[2] = '{6000, 16000};
    foreach (lows[i]) begin
      repeat (80) @(posedge aclk);
      hot_req <= 1'b1;
      short_req <= 1'b1;
      repeat (4) @(posedge aclk);
      hot_req <= 1'b0;
      short_req <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(fault_n, 1'b0);
      rd(8'h08);
      chk(d, 32'h0000_0014);
      wr(8'h00, 32'h0000_0004);
      repeat (lows[i]) @(posedge aclk);
      chk(charge_pump_en, 1'b0);
      wr(8'h00, 32'h0000_0005);
      repeat (4) @(posedge aclk);
      chk(fault_n, 1'b1);
      rd(8'h08);
      chk(d, 32'h0);
    end
  endtask
  task automatic t_clear();
    hot_req <= 1'b1;
    repeat (4) @(posedge aclk);
    hot_req <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h08);
    chk(d, 32'h0000_0010);
    wr(8'h00, 32'h0000_000D);
    repeat (4) @(posedge aclk);
    rd(8'h08);
    chk(d, 32'h0);
    rd(8'h00);
    chk(d, 32'h0000_0005);
    wr(8'h00, 32'h0000_0007);
    hot_req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(fault_n, 1'b0);
    hot_req <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(fault_n, 1'b1);
    wr(8'h00, 32'h0000_0005);
  endtask
  task automatic t_sleep();
    wr(8'h00, 32'h0000_0004);
    repeat (6000) @(posedge aclk);
    chk(charge_pump_en, 1'b1);
    wr(8'h00, 32'h0000_0005);
    repeat (4) @(posedge aclk);
    chk(fault_n, 1'b1);
    wr(8'h00, 32'h0000_0004);
    repeat (23000) @(posedge aclk);
    chk(charge_pump_en, 1'b1);
    repeat (1100) @(posedge aclk);
    chk({charge_pump_en, regulator_en, logic_en, high_side_on, low_side_on}, 11'h0);
    rd(8'h04);
    chk(d[0], 1'b1);
    wr(8'h00, 32'h0000_0005);
    repeat (100) @(posedge aclk);
    chk({regulator_en, high_side_on}, 5'h14);
    wr(8'h00, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    chk({high_side_on, low_side_on, fault_n}, 9'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_bridge();
    t_fault();
    t_clear();
    t_sleep();
    finish_test();
  end
  // Run needs about 53000 cycles; the ceiling leaves margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      err_total++;
      finish_test();
    end
  end
endmodule
